/* File: design/ieas_ctrl.sv */
// enable, abort and status control of an i2c master/slave controller
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
`include "ieas_regs.svh"
module ieas_ctrl
	import ieas_pkg::*;
#(
	parameter int DW    = 8,
	parameter int DEPTH = 32
) (
	input  wire logic          sys_clk,
	input  wire logic          rst,
	input  wire logic [31:0]   reg_addr,
	input  wire logic [31:0]   reg_wdata,
	input  wire logic          reg_wr,
	input  wire logic          reg_rd,
	output logic      [31:0]   reg_rdata,
	output logic               irq,
	input  wire logic          scl_in,
	input  wire logic          sda_in,
	input  wire logic          eng_master_busy,
	input  wire logic          eng_slave_busy,
	input  wire logic          eng_rx_active,
	input  wire logic          eng_xfer_done,
	input  wire logic          eng_stop_done,
	input  wire logic          eng_tx_pop,
	input  wire logic          eng_rx_push,
	input  wire logic [DW-1:0] eng_rx_data,
	output logic               eng_enable,
	output logic               eng_stop_req,
	output logic               eng_nack_req,
	output logic               eng_tx_valid,
	output logic      [DW-1:0] eng_tx_data
);
	// ****************************************************************
	// declarations
	// ****************************************************************
	localparam ieas_reg_t en_rst_word = `IEAS_ENABLE_RST;
	ieas_fifo_if #(.W(DW)) tx_f ();
	ieas_fifo_if #(.W(DW)) rx_f ();

	ieas_abort_t ab_state_r;
	ieas_abort_t ab_state_nxt;

	logic             en_ctrl_r;
	logic [`IEAS_EN_DELAY-1:0] en_pipe_r;
	logic             en_eff;
	logic             abort_r;
	logic             tx_locked_r;
	logic             mst_busy_r;
	logic             slv_busy_r;
	logic             bus_busy_r;
	logic             activity;
	logic [1:0]       pins_sync;
	logic             scl_s;
	logic             sda_s;
	logic             scl_d_r;
	logic             sda_d_r;
	logic             start_det;
	logic             stop_det;
	logic [2:0]       irq_stat_r;
	logic [2:0]       irq_mask_r;
	logic [2:0]       irq_evt;
	logic [2:0]       irq_w1c;
	logic             rx_full_d_r;
	logic             wr_enable;
	logic             wr_data;
	logic             rd_data;
	logic             rd_clr_abrt;
	logic             abort_flush;
	ieas_reg_t        status_word;
	ieas_reg_t        rd_word;

	// ****************************************************************
	// register decode
	// ****************************************************************
	assign wr_enable   = reg_wr && (reg_addr == `IEAS_ADDR_ENABLE);
	assign wr_data     = reg_wr && (reg_addr == `IEAS_ADDR_DATA);
	assign rd_data     = reg_rd && (reg_addr == `IEAS_ADDR_DATA);
	assign rd_clr_abrt = reg_rd && (reg_addr == `IEAS_ADDR_CLR_TX_ABRT);

	// ****************************************************************
	// enable bit and its two-cycle delay
	// ****************************************************************
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			en_ctrl_r <= en_rst_word[`IEAS_EN_BIT];
		end else if (wr_enable) begin
			// disabling mid-transfer is allowed; orderly shutdown is up
			// to software
			en_ctrl_r <= reg_wdata[`IEAS_EN_BIT];
		end
	end

	// the engine and fifos follow the delayed copy, not the register
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			en_pipe_r <= '0;
		end else begin
			en_pipe_r <= {en_pipe_r[`IEAS_EN_DELAY-2:0], en_ctrl_r};
		end
	end

	assign en_eff = en_pipe_r[`IEAS_EN_DELAY-1];

	// ****************************************************************
	// abort bit
	// ****************************************************************
	// a set request needs the register enable already high; zero writes
	// are ignored, only the sequencer may clear the bit
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			abort_r <= en_rst_word[`IEAS_ABORT_BIT];
		end else if (wr_enable && reg_wdata[`IEAS_ABORT_BIT] &&
			en_ctrl_r) begin
			abort_r <= 1'b1;
		end else if (ab_state_r == AB_DONE) begin
			abort_r <= 1'b0;
		end
	end

	// ****************************************************************
	// abort sequencer
	// ****************************************************************
	always_comb begin
		ab_state_nxt = ab_state_r;
		case (ab_state_r)
			AB_IDLE: begin
				if (abort_r) begin
					ab_state_nxt = AB_FINISH;
				end
			end
			AB_FINISH: begin
				// let the byte on the wire complete first
				if (eng_xfer_done || !mst_busy_r) begin
					ab_state_nxt = AB_STOP;
				end
			end
			AB_STOP: begin
				if (eng_stop_done || !mst_busy_r) begin
					ab_state_nxt = AB_FLUSH;
				end
			end
			AB_FLUSH: begin
				ab_state_nxt = AB_DONE;
			end
			AB_DONE: begin
				ab_state_nxt = AB_IDLE;
			end
			default: begin
				ab_state_nxt = AB_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ab_state_r <= AB_IDLE;
		end else begin
			ab_state_r <= ab_state_nxt;
		end
	end

	assign abort_flush = (ab_state_r == AB_FLUSH);

	// the stop request holds until the engine reports the stop or idles
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			eng_stop_req <= 1'b0;
		end else begin
			eng_stop_req <= (ab_state_nxt == AB_STOP);
		end
	end

	// after an abort flush the tx fifo refuses writes until released
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			tx_locked_r <= 1'b0;
		end else if (abort_flush) begin
			tx_locked_r <= 1'b1;
		end else if (rd_clr_abrt) begin
			tx_locked_r <= 1'b0;
		end
	end

	// ****************************************************************
	// fifos
	// ****************************************************************
	// a disabled controller holds both fifos flushed; the byte already
	// handed to the engine still completes on the wire
	assign tx_f.flush = !en_eff || abort_flush;
	assign tx_f.push  = wr_data && en_eff && !tx_locked_r;
	assign tx_f.wdata = reg_wdata[DW-1:0];
	assign tx_f.pop   = eng_tx_pop;
	assign rx_f.flush = !en_eff;
	assign rx_f.push  = eng_rx_push && en_eff;
	assign rx_f.wdata = eng_rx_data;
	assign rx_f.pop   = rd_data;

	ieas_fifo #(.W(DW), .DEPTH(DEPTH)) u_tx_fifo (
		.sys_clk (sys_clk),
		.rst     (rst),
		.f       (tx_f.owner)
	);

	ieas_fifo #(.W(DW), .DEPTH(DEPTH)) u_rx_fifo (
		.sys_clk (sys_clk),
		.rst     (rst),
		.f       (rx_f.owner)
	);

	// ****************************************************************
	// engine side outputs
	// ****************************************************************
	// valid and data lag the fifo by one cycle, so the engine spaces
	// its pops by at least two cycles
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			eng_enable   <= 1'b0;
			eng_nack_req <= 1'b0;
			eng_tx_valid <= 1'b0;
			eng_tx_data  <= '0;
		end else begin
			eng_enable   <= en_eff;
			eng_nack_req <= !en_eff && eng_rx_active;
			eng_tx_valid <= !tx_f.empty && !tx_f.flush && !tx_f.pop;
			eng_tx_data  <= tx_f.rdata;
		end
	end

	// ****************************************************************
	// bus activity monitor
	// ****************************************************************
	ieas_sync #(.W(2)) u_pin_sync (
		.sys_clk (sys_clk),
		.rst     (rst),
		.pin_in  ({scl_in, sda_in}),
		.pin_out (pins_sync)
	);

	assign scl_s     = pins_sync[1];
	assign sda_s     = pins_sync[0];
	assign start_det = scl_s && scl_d_r && sda_d_r && !sda_s;
	assign stop_det  = scl_s && scl_d_r && !sda_d_r && sda_s;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			scl_d_r    <= 1'b1;
			sda_d_r    <= 1'b1;
			bus_busy_r <= 1'b0;
		end else begin
			scl_d_r <= scl_s;
			sda_d_r <= sda_s;
			if (start_det) begin
				bus_busy_r <= 1'b1;
			end else if (stop_det) begin
				bus_busy_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			mst_busy_r <= 1'b0;
			slv_busy_r <= 1'b0;
		end else begin
			mst_busy_r <= eng_master_busy;
			slv_busy_r <= eng_slave_busy;
		end
	end

	assign activity = mst_busy_r || slv_busy_r || bus_busy_r;

	// ****************************************************************
	// interrupt status and mask
	// ****************************************************************
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rx_full_d_r <= 1'b0;
		end else begin
			rx_full_d_r <= rx_f.full;
		end
	end

	// tx empty raises no event of its own
	assign irq_evt[`IEAS_IRQ_TX_ABRT]  = (ab_state_r == AB_DONE);
	assign irq_evt[`IEAS_IRQ_RX_FULL]  = rx_f.full && !rx_full_d_r;
	assign irq_evt[`IEAS_IRQ_STOP_DET] = stop_det;

	always_comb begin
		irq_w1c = '0;
		if (reg_wr && (reg_addr == `IEAS_ADDR_IRQ_STAT)) begin
			irq_w1c = reg_wdata[2:0];
		end
		if (rd_clr_abrt) begin
			irq_w1c[`IEAS_IRQ_TX_ABRT] = 1'b1;
		end
		// bits survive a disable and drop only once idle
		if (!en_eff && !activity) begin
			irq_w1c = '1;
		end
	end

	// a new event in the clearing cycle wins over the clear
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			irq_stat_r <= `IEAS_IRQ_RST;
		end else begin
			irq_stat_r <= (irq_stat_r & ~irq_w1c) | irq_evt;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			irq_mask_r <= `IEAS_IRQ_RST;
		end else if (reg_wr && (reg_addr == `IEAS_ADDR_IRQ_MASK)) begin
			irq_mask_r <= reg_wdata[2:0];
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_stat_r & irq_mask_r);
		end
	end

	// ****************************************************************
	// status word and read path
	// ****************************************************************
	always_comb begin
		status_word = '0;
		status_word[`IEAS_ST_SLV_BUSY]    = slv_busy_r;
		status_word[`IEAS_ST_MST_BUSY]    = mst_busy_r;
		status_word[`IEAS_ST_RX_FULL]     = rx_f.full;
		status_word[`IEAS_ST_RX_NONEMPTY] = !rx_f.empty;
		status_word[`IEAS_ST_TX_EMPTY]    = tx_f.empty;
		status_word[`IEAS_ST_TX_SPACE]    = !tx_f.full;
		status_word[`IEAS_ST_ACTIVITY]    = activity;
	end

	always_comb begin
		rd_word = '0;
		case (reg_addr)
			`IEAS_ADDR_ENABLE: begin
				rd_word[`IEAS_EN_BIT]    = en_ctrl_r;
				rd_word[`IEAS_ABORT_BIT] = abort_r;
			end
			`IEAS_ADDR_STATUS: begin
				rd_word = status_word;
			end
			`IEAS_ADDR_DATA: begin
				rd_word[DW-1:0] = rx_f.empty ? '0 : rx_f.rdata;
			end
			`IEAS_ADDR_IRQ_STAT: begin
				rd_word[2:0] = irq_stat_r;
			end
			`IEAS_ADDR_IRQ_MASK: begin
				rd_word[2:0] = irq_mask_r;
			end
			default: begin
				rd_word = '0;
			end
		endcase
	end

	// read data stand for exactly the cycle after the strobe
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= '0;
		end else if (reg_rd) begin
			reg_rdata <= {16'h0000, rd_word};
		end else begin
			reg_rdata <= '0;
		end
	end
endmodule // ieas_ctrl

/* File: design/ieas_regs.svh */
// register offsets, field positions, reset values and timing counts
`ifndef IEAS_REGS_SVH
`define IEAS_REGS_SVH

// ****************************************************************
// register byte addresses
// ****************************************************************
`define IEAS_ADDR_DATA        32'h5000_1310
`define IEAS_ADDR_CLR_TX_ABRT 32'h5000_1354
`define IEAS_ADDR_ENABLE      32'h5000_136c
`define IEAS_ADDR_STATUS      32'h5000_1370
`define IEAS_ADDR_IRQ_STAT    32'h5000_13a0
`define IEAS_ADDR_IRQ_MASK    32'h5000_13a4

// ****************************************************************
// field positions
// ****************************************************************
`define IEAS_EN_BIT           0
`define IEAS_ABORT_BIT        1
`define IEAS_ST_ACTIVITY      0
`define IEAS_ST_TX_SPACE      1
`define IEAS_ST_TX_EMPTY      2
`define IEAS_ST_RX_NONEMPTY   3
`define IEAS_ST_RX_FULL       4
`define IEAS_ST_MST_BUSY      5
`define IEAS_ST_SLV_BUSY      6
`define IEAS_IRQ_TX_ABRT      0
`define IEAS_IRQ_RX_FULL      1
`define IEAS_IRQ_STOP_DET     2

// ****************************************************************
// reset values and timing
// ****************************************************************
`define IEAS_ENABLE_RST       16'h0000
`define IEAS_STATUS_RST       16'h0006
`define IEAS_IRQ_RST          3'h0
`define IEAS_EN_DELAY         2

`endif

/* File: design/ieas_pkg.sv */
// types shared by the enable, abort and status block
package ieas_pkg;

	typedef logic [15:0] ieas_reg_t;

	// one-hot abort sequencer states
	typedef enum logic [4:0] {
		AB_IDLE   = 5'b00001,
		AB_FINISH = 5'b00010,
		AB_STOP   = 5'b00100,
		AB_FLUSH  = 5'b01000,
		AB_DONE   = 5'b10000
	} ieas_abort_t;

endpackage

/* File: design/ieas_fifo_if.sv */
// fifo carrier between the controller core and its fifos
`timescale 1ns/1ps
interface ieas_fifo_if #(
	parameter int W = 8
);
	logic         push;
	logic         pop;
	logic         flush;
	logic [W-1:0] wdata;
	logic [W-1:0] rdata;
	logic         full;
	logic         empty;

	modport owner (
		input  push, pop, flush, wdata,
		output rdata, full, empty
	);
	modport user (
		output push, pop, flush, wdata,
		input  rdata, full, empty
	);
endinterface

/* File: design/ieas_sync.sv */
// three-stage pin sampler; a change counts once stages two and three agree
`timescale 1ns/1ps
module ieas_sync #(
	parameter int W = 2
) (
	input  wire logic         sys_clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] pin_in,
	output logic      [W-1:0] pin_out
);
	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;

	// idle bus lines are high, so start from one
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			s1_r    <= '1;
			s2_r    <= '1;
			s3_r    <= '1;
			pin_out <= '1;
		end else begin
			s1_r <= pin_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
			for (int i = 0; i < W; i++) begin
				if (s2_r[i] == s3_r[i]) begin
					pin_out[i] <= s3_r[i];
				end
			end
		end
	end
endmodule // ieas_sync

/* File: design/ieas_fifo.sv */
// small synchronous fifo with registered full and empty flags
`timescale 1ns/1ps
module ieas_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 32
) (
	input  wire logic   sys_clk,
	input  wire logic   rst,
	ieas_fifo_if.owner  f
);
	localparam int AW = $clog2(DEPTH);

	logic [W-1:0]  mem [DEPTH];
	logic [AW-1:0] wr_ptr_r;
	logic [AW-1:0] rd_ptr_r;
	logic [AW:0]   count_r;
	logic [AW:0]   count_nxt;
	logic          do_push;
	logic          do_pop;

	assign do_push = f.push && !f.full;
	assign do_pop  = f.pop && !f.empty;
	assign f.rdata = mem[rd_ptr_r];

	always_comb begin
		count_nxt = count_r;
		if (do_push && !do_pop) begin
			count_nxt = count_r + (AW+1)'(1);
		end else if (do_pop && !do_push) begin
			count_nxt = count_r - (AW+1)'(1);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (do_push && !f.flush) begin
			mem[wr_ptr_r] <= f.wdata;
		end
	end

	// flush wins over push and pop so a held flush keeps it empty
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r  <= '0;
			f.full   <= 1'b0;
			f.empty  <= 1'b1;
		end else if (f.flush) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r  <= '0;
			f.full   <= 1'b0;
			f.empty  <= 1'b1;
		end else begin
			if (do_push) begin
				wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + AW'(1);
			end
			if (do_pop) begin
				rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + AW'(1);
			end
			count_r <= count_nxt;
			f.full  <= (count_nxt == (AW+1)'(DEPTH));
			f.empty <= (count_nxt == '0);
		end
	end
endmodule // ieas_fifo

/* File: bench/ieas_ctrl_asserts.sv */
// port checker for the enable, abort and status block
`timescale 1ns/1ps
`include "ieas_regs.svh"
module ieas_ctrl_chk #(
	parameter int DW    = 8,
	parameter int DEPTH = 32
) (
	input wire logic          sys_clk,
	input wire logic          rst,
	input wire logic [31:0]   reg_addr,
	input wire logic [31:0]   reg_wdata,
	input wire logic          reg_wr,
	input wire logic          reg_rd,
	input wire logic [31:0]   reg_rdata,
	input wire logic          irq,
	input wire logic          scl_in,
	input wire logic          sda_in,
	input wire logic          eng_master_busy,
	input wire logic          eng_slave_busy,
	input wire logic          eng_rx_active,
	input wire logic          eng_xfer_done,
	input wire logic          eng_stop_done,
	input wire logic          eng_tx_pop,
	input wire logic          eng_rx_push,
	input wire logic [DW-1:0] eng_rx_data,
	input wire logic          eng_enable,
	input wire logic          eng_stop_req,
	input wire logic          eng_nack_req,
	input wire logic          eng_tx_valid,
	input wire logic [DW-1:0] eng_tx_data
);
	// ****************************************************************
	// assertions
	// ****************************************************************
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	wire en_wr = reg_wr && reg_addr == `IEAS_ADDR_ENABLE;
	wire st_rd = reg_rd && reg_addr == `IEAS_ADDR_STATUS;
	logic en_sw_r;

	// software view of the enable bit; the port copy lags it by cycles
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			en_sw_r <= 1'b0;
		end else if (en_wr) begin
			en_sw_r <= reg_wdata[0];
		end
	end

	AST_EN_DELAY: assert property (
		en_wr |-> ##4 eng_enable == $past(reg_wdata[0], 4))
		else $error("enable change not seen four edges after write");
	AST_NACK: assert property (
		eng_nack_req == (!eng_enable && $past(eng_rx_active)))
		else $error("nack request does not follow disable");
	AST_TX_HELD: assert property (
		!eng_enable [*2] |-> !eng_tx_valid)
		else $error("tx data offered while disabled");
	AST_MST_BIT: assert property (
		st_rd && $stable(eng_master_busy)
		|=> reg_rdata[5] == $past(eng_master_busy))
		else $error("master busy bit wrong");
	AST_SLV_BIT: assert property (
		st_rd && $stable(eng_slave_busy)
		|=> reg_rdata[6] == $past(eng_slave_busy))
		else $error("slave busy bit wrong");
	AST_STOP_FLUSH: assert property (
		$fell(eng_stop_req) |-> ##[0:4] !eng_tx_valid)
		else $error("tx fifo not flushed after stop");
	AST_ABORT_IGNORED: assert property (
		en_wr && reg_wdata[1:0] == 2'b10 && !en_sw_r && !eng_stop_req
		|=> !eng_stop_req [*8])
		else $error("abort accepted while disabled");
	AST_EN_FIELDS: assert property (
		reg_rd && reg_addr == `IEAS_ADDR_ENABLE |=> reg_rdata[31:2] == '0)
		else $error("reserved enable bits not zero");

	// main scenarios reached
	COV_STOP: cover property (eng_stop_req);
	COV_NACK: cover property (eng_nack_req);
	COV_IRQ: cover property (irq);
endmodule // ieas_ctrl_chk

bind ieas_ctrl ieas_ctrl_chk #(.DW(DW), .DEPTH(DEPTH)) u_chk (
	.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .irq(irq), .scl_in(scl_in), .sda_in(sda_in),
	.eng_master_busy(eng_master_busy), .eng_slave_busy(eng_slave_busy),
	.eng_rx_active(eng_rx_active), .eng_xfer_done(eng_xfer_done),
	.eng_stop_done(eng_stop_done), .eng_tx_pop(eng_tx_pop),
	.eng_rx_push(eng_rx_push), .eng_rx_data(eng_rx_data),
	.eng_enable(eng_enable), .eng_stop_req(eng_stop_req),
	.eng_nack_req(eng_nack_req), .eng_tx_valid(eng_tx_valid),
	.eng_tx_data(eng_tx_data));

/* File: bench/ieas_bus_peer.sv */
// other bus master: one start, nine bits, stop per request
`timescale 1ns/1ps
module ieas_bus_peer (
	input  wire logic go,
	output logic      scl,
	output logic      sda
);
	// ****************************************************************
	// frame generator
	// ****************************************************************
	// pull-ups hold both lines high; scl stands still between frames
	initial begin
		scl = 1'b1;
		sda = 1'b1;
	end
	always @(posedge go) begin
		#130 sda = 1'b0;
		#100 scl = 1'b0;
		repeat (9) begin
			#50 sda = ~sda;
			#50 scl = 1'b1;
			#100 scl = 1'b0;
		end
		#50 sda = 1'b0;
		#50 scl = 1'b1;
		#100 sda = 1'b1;
	end
endmodule // ieas_bus_peer

/* File: bench/ieas_ctrl_tb.sv */
// self-checking bench for the enable, abort and status block
`timescale 1ns/1ps
`include "ieas_regs.svh"
module ieas_ctrl_tb
	import ieas_pkg::*;
;
	logic        sys_clk, rst, reg_wr, reg_rd, irq, go, scl, sda;
	logic [31:0] reg_addr, reg_wdata, reg_rdata;
	logic        m_busy, s_busy, rx_act, x_done, s_done, pop, push;
	logic [7:0]  rx_d, tx_d;
	logic        en_o, stop_o, nack_o, txv_o;
	int          bad_count, cmp_count;
	localparam logic [31:0] A_EN = `IEAS_ADDR_ENABLE;
	localparam logic [31:0] A_ST = `IEAS_ADDR_STATUS;
	localparam logic [31:0] A_DT = `IEAS_ADDR_DATA;
	localparam logic [31:0] A_IM = `IEAS_ADDR_IRQ_MASK;

	ieas_ctrl #(.DW(8), .DEPTH(32)) DUT (
		.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .irq(irq), .scl_in(scl), .sda_in(sda),
		.eng_master_busy(m_busy), .eng_slave_busy(s_busy),
		.eng_rx_active(rx_act), .eng_xfer_done(x_done),
		.eng_stop_done(s_done), .eng_tx_pop(pop), .eng_rx_push(push),
		.eng_rx_data(rx_d), .eng_enable(en_o), .eng_stop_req(stop_o),
		.eng_nack_req(nack_o), .eng_tx_valid(txv_o), .eng_tx_data(tx_d));
	ieas_bus_peer u_peer (.go(go), .scl(scl), .sda(sda));

	// ****************************************************************
	// bus and compare tasks
	// ****************************************************************
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	task automatic wr(input logic [31:0] a, input ieas_reg_t d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= {16'h0000, d};
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rchk(input logic [31:0] a, input ieas_reg_t e,
		input string m);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(negedge sys_clk);
		chk_reg(reg_rdata[15:0], e, m);
	endtask
	task automatic chk_reg(input ieas_reg_t g, input ieas_reg_t e,
		input string m);
		cmp_count++;
		if (g !== e) begin
			bad_count++;
			$display("wrong value at %0t: %s got %h", $time, m, g);
		end
	endtask
	task automatic chk_bit(input logic g, input logic e, input string m);
		cmp_count++;
		if (g !== e) begin
			bad_count++;
			$display("wrong value at %0t: %s got %b", $time, m, g);
		end
	endtask
	task automatic wait_neg(input int n);
		repeat (n) @(negedge sys_clk);
	endtask

	// ****************************************************************
	// scenarios
	// ****************************************************************
	task automatic t_reset;
		rchk(A_EN, 16'h0000, "enable reset");
		rchk(A_ST, 16'h0006, "status reset");
		rchk(32'h5000_13fc, 16'h0000, "unmapped read");
		wr(A_EN, 16'h0002);
		rchk(A_EN, 16'h0000, "abort while disabled");
		$display("test reset done");
	endtask
	task automatic t_enable;
		wr(A_EN, 16'h0001);
		wait_neg(3);
		chk_bit(en_o, 1'b0, "enable too early");
		wait_neg(1);
		chk_bit(en_o, 1'b1, "enable too late");
		$display("test enable done");
	endtask
	task automatic t_abort;
		@(posedge sys_clk) m_busy <= 1'b1;
		wr(A_DT, 16'h00a5);
		wr(A_DT, 16'h005a);
		rchk(A_ST, 16'h0023, "master busy");
		wr(A_EN, 16'h0003);
		rchk(A_EN, 16'h0003, "abort running");
		wr(A_EN, 16'h0001);
		rchk(A_EN, 16'h0003, "abort kept");
		chk_bit(stop_o, 1'b0, "stop before transfer end");
		@(posedge sys_clk) x_done <= 1'b1;
		@(posedge sys_clk) x_done <= 1'b0;
		for (int i = 0; i < 8 && !stop_o; i++) @(negedge sys_clk);
		chk_bit(stop_o, 1'b1, "stop request");
		rchk(A_ST, 16'h0023, "no flush before stop");
		@(posedge sys_clk) s_done <= 1'b1;
		@(posedge sys_clk) s_done <= 1'b0;
		m_busy <= 1'b0;
		wait_neg(4);
		rchk(A_EN, 16'h0001, "abort self clear");
		rchk(A_ST, 16'h0006, "tx flushed");
		chk_bit(irq, 1'b0, "masked abort irq");
		wr(A_IM, 16'h0001);
		wait_neg(2);
		chk_bit(irq, 1'b1, "abort irq");
		wr(A_DT, 16'h0011);
		rchk(A_ST, 16'h0006, "tx locked");
		rchk(`IEAS_ADDR_CLR_TX_ABRT, 16'h0000, "clear read");
		rchk(`IEAS_ADDR_IRQ_STAT, 16'h0000, "abort irq gone");
		chk_bit(irq, 1'b0, "irq low");
		wr(A_DT, 16'h0011);
		rchk(A_ST, 16'h0002, "tx accepts again");
		chk_reg({8'h00, tx_d}, 16'h0011, "tx head");
		chk_bit(txv_o, 1'b1, "tx valid after unlock");
		@(posedge sys_clk) pop <= 1'b1;
		@(posedge sys_clk) pop <= 1'b0;
		$display("test abort done");
	endtask
	task automatic t_fifo;
		for (int i = 0; i < 32; i++) wr(A_DT, 16'(i));
		rchk(A_ST, 16'h0000, "tx full");
		for (int i = 0; i < 32; i++) begin
			@(posedge sys_clk);
			push <= 1'b1;
			rx_d <= 8'(8'h40 + i);
			@(posedge sys_clk) push <= 1'b0;
		end
		rchk(A_ST, 16'h0018, "rx full");
		rchk(A_DT, 16'h0040, "rx head");
		rchk(A_ST, 16'h0008, "rx one free");
		@(posedge sys_clk) rx_act <= 1'b1;
		wr(A_EN, 16'h0000);
		wait_neg(4);
		chk_bit(nack_o, 1'b1, "no ack when disabled");
		rchk(A_ST, 16'h0006, "fifos flushed");
		@(posedge sys_clk) push <= 1'b1;
		@(posedge sys_clk) push <= 1'b0;
		rx_act <= 1'b0;
		rchk(A_ST, 16'h0006, "rx held empty");
		$display("test fifo done");
	endtask
	task automatic t_activity;
		wr(A_EN, 16'h0001);
		@(posedge sys_clk) s_busy <= 1'b1;
		rchk(A_ST, 16'h0047, "slave busy");
		wr(A_IM, 16'h0004);
		@(posedge sys_clk) go <= 1'b1;
		for (int i = 0; i < 300 && !irq; i++) @(negedge sys_clk);
		chk_bit(irq, 1'b1, "stop seen");
		go <= 1'b0;
		wr(A_EN, 16'h0000);
		wait_neg(6);
		chk_bit(irq, 1'b1, "irq kept while busy");
		@(posedge sys_clk) s_busy <= 1'b0;
		wait_neg(6);
		chk_bit(irq, 1'b0, "irq cleared at idle");
		rchk(A_ST, 16'h0006, "all idle");
		$display("test activity done");
	endtask

	// ****************************************************************
	// run control
	// ****************************************************************
	task automatic test_done;
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		{rst, reg_wr, reg_rd, go, m_busy, s_busy} = 6'b10_0000;
		{rx_act, x_done, s_done, pop, push} = 5'b0_0000;
		{reg_addr, reg_wdata, rx_d} = '0;
		repeat (6) @(posedge sys_clk);
		rst <= 1'b0;
		t_reset;
		t_enable;
		t_abort;
		t_fifo;
		t_activity;
		test_done;
	end
	// the run needs well under 2000 cycles
	initial begin
		#300000;
		bad_count++;
		$display("wrong value at %0t: watchdog expired", $time);
		test_done;
	end
endmodule // ieas_ctrl_tb
